/* include/core_ops_pkg.sv */
// Constants, encodings and carrier types for the watchdog-clear and decrement core ops.
// Assumes one core clock and a synchronous, active-low reset everywhere.
// Operation
// RL1 - Watchdog clear: zero counter, prescaler; set status
// RL2 - Decrement file register; destination bit picks target
// RL3 - Plain decrement updates zero flag, one cycle
// RL4 - Decrement-skip routes alike, leaves flags unchanged
// RL5 - Zero result discards next instruction as no-op
// RL6 - File field 0..127, destination bit 0/1
// RL7 - One 14-bit word; leading 00 selects group
package core_ops_pkg;

	// ==========================================================
	// Widths
	localparam int INSTR_W = 14;
	localparam int FADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int FILE_DEPTH = 128;
	localparam int BUS_AW = 10;
	localparam int BUS_DW = 32;

	// ==========================================================
	// Register byte offsets
	localparam logic [BUS_AW-1:0] CTRL_OFS = 10'h000;
	localparam logic [BUS_AW-1:0] STATUS_OFS = 10'h004;
	localparam logic [BUS_AW-1:0] WREG_OFS = 10'h008;
	localparam logic [BUS_AW-1:0] FILE_BASE_OFS = 10'h200;
	localparam int FILE_WIN_BIT = 9;

	// ==========================================================
	// Field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int ST_ZERO_BIT = 0;
	localparam int ST_PD_BIT = 1;
	localparam int ST_TO_BIT = 2;
	localparam int ST_SKIP_BIT = 3;

	// ==========================================================
	// Values after reset
	localparam logic CTRL_EN_RST = 1'b0;
	localparam logic [DATA_W-1:0] WREG_RST = 8'h00;
	localparam logic ZERO_RST = 1'b0;
	localparam logic TO_RST = 1'b1;
	localparam logic PD_RST = 1'b1;

	// ==========================================================
	// Instruction encodings
	localparam logic [1:0] GROUP_BYTE = 2'b00;
	localparam logic [INSTR_W-1:0] CLEAR_WATCHDOG_WORD = 14'h0064;
	localparam logic [3:0] DECREMENT_OPC = 4'h3;
	localparam logic [3:0] DECREMENT_SKIP_OPC = 4'hb;
	localparam logic [DATA_W-1:0] DEC_STEP = 8'h01;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		OP_NO_OPERATION,
		OP_CLEAR_WATCHDOG,
		OP_DECREMENT,
		OP_DECREMENT_SKIP
	} op_t;

	typedef enum logic {
		EX_RUN,
		EX_SKIP
	} exec_state_t;

	typedef struct packed {
		op_t op;
		logic dest;
		logic [FADDR_W-1:0] faddr;
	} decoded_t;

	typedef struct packed {
		logic timeout;
		logic powerdown;
		logic zero;
	} status_t;

endpackage : core_ops_pkg

/* hw/instr_decoder.sv */
// Decodes one instruction word into operation, destination and file address.
// Assumes the word is stable while it is offered; purely combinational.
module instr_decoder
	import core_ops_pkg::*;
(
	input wire logic [INSTR_W-1:0] i_instr,
	output decoded_t o_dec
);

	// ==========================================================
	// Decode
	always_comb begin
		o_dec.dest = i_instr[FADDR_W]; // [RL6]
		o_dec.faddr = i_instr[FADDR_W-1:0]; // [RL6]
		o_dec.op = OP_NO_OPERATION;
		// Anything outside the three ops runs as a no-op here
		if (i_instr[INSTR_W-1:INSTR_W-2] == GROUP_BYTE) begin // [RL7]
			if (i_instr == CLEAR_WATCHDOG_WORD) begin
				o_dec.op = OP_CLEAR_WATCHDOG;
			end else if (i_instr[11:8] == DECREMENT_OPC) begin
				o_dec.op = OP_DECREMENT;
			end else if (i_instr[11:8] == DECREMENT_SKIP_OPC) begin
				o_dec.op = OP_DECREMENT_SKIP;
			end
		end
	end

endmodule : instr_decoder

/* hw/file_reg_bank.sv */
// File register space: 128 bytes, one write port, two asynchronous read ports.
// Assumes the caller never asks for two writes in one cycle.
module file_reg_bank
	import core_ops_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_wr_en,
	input wire logic [FADDR_W-1:0] i_wr_addr,
	input wire logic [DATA_W-1:0] i_wr_data,
	input wire logic [FADDR_W-1:0] i_rd_addr_a,
	output logic [DATA_W-1:0] o_rd_data_a,
	input wire logic [FADDR_W-1:0] i_rd_addr_b,
	output logic [DATA_W-1:0] o_rd_data_b
);

	// ==========================================================
	// Storage
	// Contents are not reset, as in a real register file
	logic [DATA_W-1:0] mem [FILE_DEPTH];

	always_ff @(posedge i_clk) begin
		if (i_wr_en) begin
			mem[i_wr_addr] <= i_wr_data;
		end
	end

	assign o_rd_data_a = mem[i_rd_addr_a];
	assign o_rd_data_b = mem[i_rd_addr_b];

endmodule : file_reg_bank

/* hw/core_exec.sv */
// Execution of watchdog clear, decrement and decrement-skip, with an Avalon-MM register slave.
// Assumes instructions arrive by valid/ready from fetch, one per accepted cycle.
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
module core_exec
	import core_ops_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [BUS_AW-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [BUS_DW-1:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [BUS_DW-1:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic [INSTR_W-1:0] i_instr,
	input wire logic i_instr_valid,
	output logic o_instr_ready,
	output logic o_wdt_clear,
	output logic o_skip_nop,
	output logic o_zero_flag,
	output logic o_timeout_status,
	output logic o_powerdown_status,
	output logic [DATA_W-1:0] o_wreg
);

	// ==========================================================
	// Declarations
	decoded_t dec;
	op_t eff_op;
	exec_state_t state_reg;
	status_t status_reg;
	logic ctrl_en_reg;
	logic [DATA_W-1:0] w_reg;
	logic bus_ack_reg;
	logic [BUS_DW-1:0] readdata_reg;
	logic wdt_clear_reg;
	logic skip_nop_reg;
	logic bus_req;
	logic bus_fire;
	logic bus_wr;
	logic accept;
	logic is_dec;
	logic [DATA_W-1:0] file_rd_a;
	logic [DATA_W-1:0] file_rd_b;
	logic [DATA_W-1:0] result;
	logic result_zero;
	logic bank_wr_en;
	logic [FADDR_W-1:0] bank_wr_addr;
	logic [DATA_W-1:0] bank_wr_data;
	logic bus_file_hit;
	logic [BUS_DW-1:0] read_mux;

	// ==========================================================
	// Submodules
	instr_decoder u_decoder (
		.i_instr(i_instr),
		.o_dec(dec)
	);

	file_reg_bank u_bank (
		.i_clk(i_clk),
		.i_wr_en(bank_wr_en),
		.i_wr_addr(bank_wr_addr),
		.i_wr_data(bank_wr_data),
		.i_rd_addr_a(dec.faddr),
		.o_rd_data_a(file_rd_a),
		.i_rd_addr_b(i_avs_address[FADDR_W+1:2]),
		.o_rd_data_b(file_rd_b)
	);

	// ==========================================================
	// Avalon slave handshake
	// Fixed two-cycle answer: data is muxed in cycle one, presented in cycle two
	assign bus_req = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = bus_req & ~bus_ack_reg;
	assign bus_fire = bus_req & bus_ack_reg;
	assign bus_wr = bus_fire & i_avs_write;
	assign bus_file_hit = i_avs_address[FILE_WIN_BIT];

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			bus_ack_reg <= 1'b0;
		end else begin
			bus_ack_reg <= bus_req & ~bus_ack_reg;
		end
	end

	always_comb begin
		read_mux = 32'h0000_0000;
		if (bus_file_hit) begin
			read_mux[DATA_W-1:0] = file_rd_b;
		end else begin
			unique case (i_avs_address)
				CTRL_OFS: read_mux[CTRL_EN_BIT] = ctrl_en_reg;
				STATUS_OFS: begin
					read_mux[ST_ZERO_BIT] = status_reg.zero;
					read_mux[ST_PD_BIT] = status_reg.powerdown;
					read_mux[ST_TO_BIT] = status_reg.timeout;
					read_mux[ST_SKIP_BIT] = (state_reg == EX_SKIP);
				end
				WREG_OFS: read_mux[DATA_W-1:0] = w_reg;
				default: read_mux = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			readdata_reg <= 32'h0000_0000;
		end else if (i_avs_read & ~bus_ack_reg) begin
			readdata_reg <= read_mux;
		end
	end

	assign o_avs_readdata = readdata_reg;

	// ==========================================================
	// Instruction acceptance
	// Bus traffic stalls fetch, so core and bus never write in one cycle
	assign o_instr_ready = ctrl_en_reg & ~bus_req;
	assign accept = i_instr_valid & o_instr_ready;
	assign eff_op = (state_reg == EX_SKIP) ? OP_NO_OPERATION : dec.op; // [RL5]
	assign is_dec = (eff_op == OP_DECREMENT) | (eff_op == OP_DECREMENT_SKIP);
	assign result = file_rd_a - DEC_STEP; // [RL2]
	assign result_zero = (result == 8'h00);

	// ==========================================================
	// File register write port
	always_comb begin
		bank_wr_en = 1'b0;
		bank_wr_addr = dec.faddr;
		bank_wr_data = result;
		if (accept & is_dec & dec.dest) begin // [RL2] [RL4]
			bank_wr_en = 1'b1;
		end else if (bus_wr & bus_file_hit & i_avs_byteenable[0]) begin
			bank_wr_en = 1'b1;
			bank_wr_addr = i_avs_address[FADDR_W+1:2];
			bank_wr_data = i_avs_writedata[DATA_W-1:0];
		end
	end

	// ==========================================================
	// Control register
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			ctrl_en_reg <= CTRL_EN_RST;
		end else if (bus_wr & (i_avs_address == CTRL_OFS) & i_avs_byteenable[0]) begin
			ctrl_en_reg <= i_avs_writedata[CTRL_EN_BIT];
		end
	end

	// ==========================================================
	// Working register
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			w_reg <= WREG_RST;
		end else if (accept & is_dec & ~dec.dest) begin
			w_reg <= result; // [RL2] [RL4]
		end else if (bus_wr & (i_avs_address == WREG_OFS) & i_avs_byteenable[0]) begin
			w_reg <= i_avs_writedata[DATA_W-1:0];
		end
	end

	// ==========================================================
	// Status bits
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			status_reg.zero <= ZERO_RST;
			status_reg.timeout <= TO_RST;
			status_reg.powerdown <= PD_RST;
		end else if (accept & (eff_op == OP_DECREMENT)) begin
			status_reg.zero <= result_zero; // [RL3]
		end else if (accept & (eff_op == OP_CLEAR_WATCHDOG)) begin
			status_reg.timeout <= 1'b1; // [RL1]
			status_reg.powerdown <= 1'b1; // [RL1]
		end else if (bus_wr & (i_avs_address == STATUS_OFS) & i_avs_byteenable[0]) begin
			status_reg.zero <= i_avs_writedata[ST_ZERO_BIT];
			status_reg.powerdown <= i_avs_writedata[ST_PD_BIT];
			status_reg.timeout <= i_avs_writedata[ST_TO_BIT];
		end
	end

	// ==========================================================
	// Skip sequencing
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			state_reg <= EX_RUN;
		end else if (accept) begin
			unique case (state_reg)
				EX_RUN: begin
					if ((dec.op == OP_DECREMENT_SKIP) & result_zero) begin
						state_reg <= EX_SKIP; // [RL5]
					end
				end
				EX_SKIP: state_reg <= EX_RUN;
			endcase
		end
	end

	// ==========================================================
	// Event outputs
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			wdt_clear_reg <= 1'b0;
			skip_nop_reg <= 1'b0;
		end else begin
			// Watchdog counter and prescaler both clear on this pulse
			wdt_clear_reg <= accept & (eff_op == OP_CLEAR_WATCHDOG); // [RL1]
			skip_nop_reg <= accept & (state_reg == EX_SKIP); // [RL5]
		end
	end

	assign o_wdt_clear = wdt_clear_reg;
	assign o_skip_nop = skip_nop_reg;
	assign o_zero_flag = status_reg.zero;
	assign o_timeout_status = status_reg.timeout;
	assign o_powerdown_status = status_reg.powerdown;
	assign o_wreg = w_reg;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// Bus and core never act in one cycle, so each check sees a single source

	// A second clear right behind the first legally stretches the pulse
	property p_clear_watchdog_instr;
		accept & (eff_op == OP_CLEAR_WATCHDOG) |=> o_wdt_clear & o_timeout_status & o_powerdown_status
			##1 o_wdt_clear == $past(accept & (eff_op == OP_CLEAR_WATCHDOG));
	endproperty
	a_clear_watchdog_instr: assert property (p_clear_watchdog_instr) else $error("watchdog clear effects missing"); // [RL1]

	property p_dec_to_w;
		accept & is_dec & !dec.dest |=> o_wreg == $past(file_rd_a) - DEC_STEP;
	endproperty
	a_dec_to_w: assert property (p_dec_to_w) else $error("decrement result not in working register"); // [RL2]

	property p_dec_to_file;
		accept & is_dec & dec.dest |-> bank_wr_en & bank_wr_addr == i_instr[FADDR_W-1:0] ##1 $stable(o_wreg);
	endproperty
	a_dec_to_file: assert property (p_dec_to_file) else $error("decrement not written back to file"); // [RL2]

	property p_dec_zero;
		accept & (eff_op == OP_DECREMENT) |=> o_zero_flag == ($past(file_rd_a) == DEC_STEP);
	endproperty
	a_dec_zero: assert property (p_dec_zero) else $error("zero flag wrong after decrement"); // [RL3]

	property p_skip_flags;
		accept & (eff_op == OP_DECREMENT_SKIP) |=>
			$stable(o_zero_flag) & $stable(o_timeout_status) & $stable(o_powerdown_status);
	endproperty
	a_skip_flags: assert property (p_skip_flags) else $error("decrement-skip changed a flag"); // [RL4]

	property p_skip_nop;
		accept & (state_reg == EX_SKIP) |-> !bank_wr_en ##1 o_skip_nop & $stable(o_wreg);
	endproperty
	a_skip_nop: assert property (p_skip_nop) else $error("next instruction not discarded"); // [RL5]

	property p_no_skip;
		accept & (eff_op == OP_DECREMENT_SKIP) & !result_zero |=> state_reg == EX_RUN;
	endproperty
	a_no_skip: assert property (p_no_skip) else $error("skip taken on nonzero result"); // [RL5]

	// Arming here is what later discards the fetched word
	property p_skip_enter;
		accept & (eff_op == OP_DECREMENT_SKIP) & result_zero |=> state_reg == EX_SKIP;
	endproperty
	a_skip_enter: assert property (p_skip_enter) else $error("zero skip result did not arm discard"); // [RL5]

	property p_skip_to_w;
		accept & (eff_op == OP_DECREMENT_SKIP) & !dec.dest |=> o_wreg == $past(file_rd_a) - DEC_STEP;
	endproperty
	a_skip_to_w: assert property (p_skip_to_w) else $error("skip result not in working register"); // [RL4]

	property p_skip_to_file;
		accept & (eff_op == OP_DECREMENT_SKIP) & dec.dest |->
			bank_wr_en & (bank_wr_data == file_rd_a - DEC_STEP) ##1 $stable(o_wreg);
	endproperty
	a_skip_to_file: assert property (p_skip_to_file) else $error("skip result not written back"); // [RL4]

	// Pulses must never appear without their cause
	property p_wdt_only;
		o_wdt_clear |-> $past(accept & (eff_op == OP_CLEAR_WATCHDOG));
	endproperty
	a_wdt_only: assert property (p_wdt_only) else $error("watchdog clear pulse without cause"); // [RL1]

	property p_skip_nop_only;
		o_skip_nop |-> $past(accept & (state_reg == EX_SKIP));
	endproperty
	a_skip_nop_only: assert property (p_skip_nop_only) else $error("discard pulse without cause"); // [RL5]

	property p_field_decode;
		(dec.op == OP_DECREMENT) |-> dec.faddr == i_instr[6:0] & dec.dest == i_instr[7];
	endproperty
	a_field_decode: assert property (p_field_decode) else $error("file field or destination misdecoded"); // [RL6]

	property p_group;
		(dec.op != OP_NO_OPERATION) |-> i_instr[13:12] == GROUP_BYTE;
	endproperty
	a_group: assert property (p_group) else $error("operation decoded outside byte group"); // [RL7]

	c_clear_watchdog_instr: cover property (accept & (eff_op == OP_CLEAR_WATCHDOG));
	c_skip: cover property (accept & (eff_op == OP_DECREMENT_SKIP) & result_zero ##1 accept);
	c_dec_zero: cover property (accept & (eff_op == OP_DECREMENT) & result_zero);
	// A stalled discard is the case back-to-back traffic would hide
	c_no_skip: cover property (accept & (eff_op == OP_DECREMENT_SKIP) & !result_zero);
	c_skip_late: cover property (accept & (state_reg == EX_SKIP));

endmodule : core_exec

/* bench/tb.sv */
// Self-checking bench for core_exec: bus tasks, instruction tasks, expected values.
// Assumes the core_ops_pkg package is compiled first; one 100 MHz clock.
module tb
	import core_ops_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Stimulus and wiring
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [BUS_AW-1:0] i_avs_address = '0;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [BUS_DW-1:0] i_avs_writedata = '0;
	logic [3:0] i_avs_byteenable = 4'h0;
	logic [BUS_DW-1:0] o_avs_readdata;
	logic o_avs_waitrequest;
	logic [INSTR_W-1:0] i_instr = '0;
	logic i_instr_valid = 1'b0;
	logic o_instr_ready, o_wdt_clear, o_skip_nop, o_zero_flag, o_timeout_status, o_powerdown_status;
	logic [DATA_W-1:0] o_wreg;
	int fails = 0;
	int compares = 0;

	always #5 i_clk = ~i_clk;

	core_exec uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest), .i_instr(i_instr), .i_instr_valid(i_instr_valid),
		.o_instr_ready(o_instr_ready), .o_wdt_clear(o_wdt_clear), .o_skip_nop(o_skip_nop),
		.o_zero_flag(o_zero_flag), .o_timeout_status(o_timeout_status),
		.o_powerdown_status(o_powerdown_status), .o_wreg(o_wreg));

	// ==========================================================
	// Compare and closing tasks
	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_word

	task automatic chk_bit(input string nm, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("FAIL %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit

	task automatic results();
		if (fails == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results

	// ==========================================================
	// Avalon master: hold until waitrequest sampled low
	// Waits have no limit of their own: only the watchdog ends a hang
	task automatic bus_wr(input logic [BUS_AW-1:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge i_clk);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_byteenable <= be;
		i_avs_write <= 1'b1;
		do begin
			@(posedge i_clk);
		end while (o_avs_waitrequest !== 1'b0);
		i_avs_write <= 1'b0;
	endtask : bus_wr

	task automatic rd_chk(input string nm, input logic [BUS_AW-1:0] a, input logic [31:0] e);
		@(posedge i_clk);
		i_avs_address <= a;
		i_avs_read <= 1'b1;
		do begin
			@(posedge i_clk);
		end while (o_avs_waitrequest !== 1'b0);
		chk_word(nm, e, o_avs_readdata);
		i_avs_read <= 1'b0;
	endtask : rd_chk

	// Returns at the accepting edge
	task automatic run(input logic [INSTR_W-1:0] w);
		@(posedge i_clk);
		i_instr <= w;
		i_instr_valid <= 1'b1;
		do begin
			@(posedge i_clk);
		end while (o_instr_ready !== 1'b1);
		i_instr_valid <= 1'b0;
	endtask : run

	// Two words with valid held high, so the second follows with no gap
	task automatic run2(input logic [INSTR_W-1:0] w0, input logic [INSTR_W-1:0] w1);
		@(posedge i_clk);
		i_instr <= w0;
		i_instr_valid <= 1'b1;
		do begin
			@(posedge i_clk);
		end while (o_instr_ready !== 1'b1);
		i_instr <= w1;
		do begin
			@(posedge i_clk);
		end while (o_instr_ready !== 1'b1);
		i_instr_valid <= 1'b0;
	endtask : run2

	function automatic logic [INSTR_W-1:0] enc(input logic [3:0] opc, input logic d, input logic [6:0] f);
		return {GROUP_BYTE, opc, d, f};
	endfunction : enc

	function automatic logic [BUS_AW-1:0] fa(input logic [6:0] f);
		return FILE_BASE_OFS + {1'b0, f, 2'b00};
	endfunction : fa

	// ==========================================================
	// Watchdog: whole sequence needs well under 20000 cycles
	initial begin
		repeat (20000) @(posedge i_clk);
		fails++;
		results();
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge i_clk);
		i_reset_n <= 1'b1;
		rd_chk("status_reset", STATUS_OFS, 32'h0000_0006);
		rd_chk("unmapped", 10'h100, 32'h0000_0000);
		bus_wr(WREG_OFS, 32'h0000_00aa, 4'h0);
		rd_chk("wreg_be_off", WREG_OFS, 32'h0000_0000);
		bus_wr(CTRL_OFS, 32'h0000_0001, 4'hf);
		// Clear both status bits so the set is visible
		bus_wr(STATUS_OFS, 32'h0000_0000, 4'hf);
		run(CLEAR_WATCHDOG_WORD);
		@(negedge i_clk);
		chk_bit("wdt_clear", 1'b1, o_wdt_clear);
		chk_bit("timeout", 1'b1, o_timeout_status);
		chk_bit("powerdown", 1'b1, o_powerdown_status);
		@(negedge i_clk);
		chk_bit("wdt_clear_end", 1'b0, o_wdt_clear);
		bus_wr(fa(7'd127), 32'h0000_0001, 4'hf);
		bus_wr(fa(7'd0), 32'h0000_0000, 4'hf);
		bus_wr(fa(7'd5), 32'h0000_0002, 4'hf);
		bus_wr(fa(7'd6), 32'h0000_0010, 4'hf);
		// Preload so a zero result is told apart from the reset value
		bus_wr(WREG_OFS, 32'h0000_0055, 4'hf);
		rd_chk("wreg_bus", WREG_OFS, 32'h0000_0055);
		// Top address, result to working register
		run(enc(DECREMENT_OPC, 1'b0, 7'd127));
		@(negedge i_clk);
		chk_word("wreg_dec", 32'h0000_0000, {24'h0, o_wreg});
		chk_bit("zero_dec", 1'b1, o_zero_flag);
		rd_chk("file127", fa(7'd127), 32'h0000_0001);
		// Bottom address, wrap past zero, written back
		run(enc(DECREMENT_OPC, 1'b1, 7'd0));
		@(negedge i_clk);
		chk_bit("zero_wrap", 1'b0, o_zero_flag);
		chk_word("wreg_kept", 32'h0000_0000, {24'h0, o_wreg});
		rd_chk("file0", fa(7'd0), 32'h0000_00ff);
		// Nonzero skip result with zero flag preset to one
		bus_wr(STATUS_OFS, 32'h0000_0007, 4'hf);
		run(enc(DECREMENT_SKIP_OPC, 1'b1, 7'd5));
		@(negedge i_clk);
		chk_bit("zero_held1", 1'b1, o_zero_flag);
		rd_chk("status_noskip", STATUS_OFS, 32'h0000_0007);
		rd_chk("file5", fa(7'd5), 32'h0000_0001);
		run(enc(DECREMENT_OPC, 1'b0, 7'd6));
		@(negedge i_clk);
		chk_bit("skip_nop_none", 1'b0, o_skip_nop);
		chk_word("wreg_after", 32'h0000_000f, {24'h0, o_wreg});
		chk_bit("zero_clr", 1'b0, o_zero_flag);
		// Zero skip result with zero flag at zero
		run(enc(DECREMENT_SKIP_OPC, 1'b0, 7'd5));
		@(negedge i_clk);
		chk_word("wreg_skip", 32'h0000_0000, {24'h0, o_wreg});
		chk_bit("zero_held0", 1'b0, o_zero_flag);
		rd_chk("status_skip", STATUS_OFS, 32'h0000_000e);
		rd_chk("file5_same", fa(7'd5), 32'h0000_0001);
		run(enc(DECREMENT_OPC, 1'b1, 7'd6));
		@(negedge i_clk);
		chk_bit("skip_nop", 1'b1, o_skip_nop);
		@(negedge i_clk);
		chk_bit("skip_nop_end", 1'b0, o_skip_nop);
		rd_chk("file6_kept", fa(7'd6), 32'h0000_0010);
		rd_chk("status_done", STATUS_OFS, 32'h0000_0006);
		run(enc(DECREMENT_OPC, 1'b1, 7'd6));
		rd_chk("file6_dec", fa(7'd6), 32'h0000_000f);
		// Zero skip with the next word offered back to back
		run2(enc(DECREMENT_SKIP_OPC, 1'b1, 7'd5), enc(DECREMENT_OPC, 1'b0, 7'd6));
		@(negedge i_clk);
		chk_bit("skip_nop_b2b", 1'b1, o_skip_nop);
		chk_word("wreg_b2b", 32'h0000_0000, {24'h0, o_wreg});
		rd_chk("file5_b2b", fa(7'd5), 32'h0000_0000);
		// Same low bits outside the byte group do nothing
		run({2'b01, DECREMENT_OPC, 1'b1, 7'd6});
		rd_chk("file6_other", fa(7'd6), 32'h0000_000f);
		// Zero flag preset so a wrong decode would clear it
		bus_wr(STATUS_OFS, 32'h0000_0007, 4'hf);
		run({2'b01, DECREMENT_OPC, 1'b0, 7'd6});
		@(negedge i_clk);
		chk_word("wreg_other", 32'h0000_0000, {24'h0, o_wreg});
		chk_bit("zero_other", 1'b1, o_zero_flag);
		// Reset again in mid-run: control, working register and status return to reset values; file contents are kept
		@(posedge i_clk);
		i_reset_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(negedge i_clk);
		chk_bit("ready_reset", 1'b0, o_instr_ready);
		chk_bit("wait_idle", 1'b0, o_avs_waitrequest);
		chk_word("wreg_reset", 32'h0000_0000, {24'h0, o_wreg});
		rd_chk("status_reset2", STATUS_OFS, 32'h0000_0006);
		results();
	end

endmodule : tb
